/* hdl/uss_status_irq.sv */
// Bus-event and request-event status flags, masks, summary latch and request irq.
// Assumes a classic Wishbone master on clk_i and event pulses from the packet engine.
//
// Contract
// - Unhandled SETUP clears endpoint 0 stalls.
// - SETUP sets summary flag; irq if unmasked.
// - Setup with DATA0 sets both toggles DATA1.
// - Bus status bit 6: bulk direction fault.
// - Bus status bit 5: high-speed host seen.
// - Bus status bit 4: resume while suspended.
// - Bus status bit 3: bus reset detected.
// - Bit 2 read-only, mirrors error detail.
// - Other bus flags clear by writing one.
// - Unmasked bus flags set summary latch.
// - Mask gates summary, never the flag.
// - Bus bits 7,1,0 read 0; mask 1.
// - Request bit 7: halt set received.
// - Request bit 6: halt clear received.
// - Request bit 5: set configuration received.
// - Request bit 3: set interface received.
// - Bits 1/0: remote wakeup set/clear.
// - Unmasked request flags OR onto irq line.
// - Request flags clear by writing one.
// - Request mask one disables; bits 4,2 one.
// - Request bits 4,2 always read zero.
// - Suspend bit arms resume detection.
//
// The Wishbone slave port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "uss_params.svh"

module uss_status_irq (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // Wishbone slave
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire uss_pkg::uss_waddr_t wb_adr_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic [31:0]      wb_dat_i,
  output logic [31:0]           wb_dat_o,
  output logic                  wb_ack_o,
  output logic                  wb_err_o,
  // Bus events from the packet engine (one-cycle pulses, same clock; error_recorded_i is a level)
  input  wire logic             bulk_direction_fault_i,
  input  wire logic             high_speed_seen_i,
  input  wire logic             resume_seen_i,
  input  wire logic             bus_reset_seen_i,
  input  wire logic             error_recorded_i,
  // Request events from the packet engine (one-cycle pulses)
  input  wire logic             halt_set_req_i,
  input  wire logic             halt_release_req_i,
  input  wire logic             config_change_req_i,
  input  wire logic             interface_change_req_i,
  input  wire logic             wakeup_arm_req_i,
  input  wire logic             wakeup_disarm_req_i,
  // Setup arrival on endpoint 0
  input  wire logic             setup_unhandled_i,
  input  wire logic             setup_data0_valid_i,
  // Endpoint 0 stall set requests from engine
  input  wire logic             ep0_rx_stall_set_i,
  input  wire logic             ep0_tx_stall_set_i,
  // Outputs
  output logic                  mcu_request_irq_line_o,
  output logic                  setup_irq_o,
  output logic                  suspend_o,
  output logic                  resume_armed_o,
  output logic                  ep0_rx_stall_o,
  output logic                  ep0_tx_stall_o,
  output logic                  ep0_rx_toggle_o,
  output logic                  ep0_tx_toggle_o
);
  import uss_pkg::*;

  uss_byte_t bus_stat_reg;              // Sticky bus event flags
  uss_byte_t bus_mask_reg;              // Bus event mask
  uss_byte_t req_stat_reg;              // Sticky request event flags
  uss_byte_t req_mask_reg;              // Request event mask
  uss_byte_t cfg_reg;                   // Engine configuration
  logic      sum_bus_reg;               // Latched bus summary
  logic      sum_setup_reg;             // Latched setup indication
  logic      sum_setup_en_reg;          // Setup interrupt enable
  logic      ep0_rx_stall_reg;          // Endpoint 0 receive stall
  logic      ep0_tx_stall_reg;          // Endpoint 0 transmit stall
  logic      ep0_rx_tog_reg;            // Endpoint 0 expected rx toggle
  logic      ep0_tx_tog_reg;            // Endpoint 0 expected tx toggle
  logic      ack_reg;                   // Single-cycle ack
  logic      err_reg;                   // Single-cycle err
  logic [31:0] rdat_reg;                // Registered read data

  logic      req;                       // Fresh access cycle
  logic      wr;                        // Write strobe, low lane enabled
  logic      hit;                       // Address is mapped
  uss_byte_t wbyte;                     // Low-lane write data
  uss_byte_t bus_set;                   // Bus event set vector
  uss_byte_t req_set;                   // Request event set vector
  uss_byte_t bus_view;                  // Bus status as read
  logic      bus_any;                   // Unmasked bus flags present

  // Word index decode, reused for hit check and writes
  function automatic logic is_idx(input uss_waddr_t a, input logic [7:0] idx);
    is_idx = (a == {22'h00_0000, idx});
  endfunction

  // Access starts when no ack/err is pending, so each request answers once
  assign req   = wb_cyc_i && wb_stb_i && !ack_reg && !err_reg;
  assign wbyte = wb_dat_i[7:0];
  assign hit   = is_idx(wb_adr_i, `USS_IDX_BUS_STAT) || is_idx(wb_adr_i, `USS_IDX_BUS_MASK)
              || is_idx(wb_adr_i, `USS_IDX_REQ_MASK) || is_idx(wb_adr_i, `USS_IDX_REQ_STAT)
              || is_idx(wb_adr_i, `USS_IDX_ENG_CFG)  || is_idx(wb_adr_i, `USS_IDX_SUMMARY)
              || is_idx(wb_adr_i, `USS_IDX_EP0_CTL);
  assign wr    = req && hit && wb_we_i && wb_sel_i[0];

  // Event vectors in bit position
  always_comb begin
    bus_set = 8'h00;
    bus_set[`USS_BS_BULK_DIR]   = bulk_direction_fault_i;
    bus_set[`USS_BS_HIGH_SPEED] = high_speed_seen_i;
    bus_set[`USS_BS_RESUME]     = resume_seen_i && cfg_reg[`USS_CFG_SUSPEND];
    bus_set[`USS_BS_BUS_RESET]  = bus_reset_seen_i;
    req_set = {halt_set_req_i, halt_release_req_i, config_change_req_i, 1'b0,
               interface_change_req_i, 1'b0, wakeup_arm_req_i, wakeup_disarm_req_i};
  end

  // Bus status as seen by software; error bit is a live mirror
  always_comb begin
    bus_view = bus_stat_reg & `USS_BS_W1C_BITS;
    bus_view[`USS_BS_ERROR] = error_recorded_i;
  end

  // Unmasked bus flags, mask only gates the summary
  assign bus_any = |(bus_view & ~bus_mask_reg);

  // Bus status flags: write-one clears, set wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_stat_reg <= `USS_RST_BUS_STAT;
    end else begin
      if (wr && is_idx(wb_adr_i, `USS_IDX_BUS_STAT)) begin
        bus_stat_reg <= ((bus_stat_reg & ~(wbyte & `USS_BS_W1C_BITS)) | bus_set)
                        & `USS_BS_W1C_BITS;
      end else begin
        bus_stat_reg <= (bus_stat_reg | bus_set) & `USS_BS_W1C_BITS;
      end
    end
  end

  // Request status flags: write-one clears, reserved stay zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      req_stat_reg <= `USS_RST_REQ_STAT;
    end else begin
      if (wr && is_idx(wb_adr_i, `USS_IDX_REQ_STAT)) begin
        req_stat_reg <= ((req_stat_reg & ~wbyte) | req_set) & `USS_RS_BITS;
      end else begin
        req_stat_reg <= (req_stat_reg | req_set) & `USS_RS_BITS;
      end
    end
  end

  // Mask registers; unused positions held at one
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_mask_reg <= `USS_RST_BUS_MASK;
      req_mask_reg <= `USS_RST_REQ_MASK;
    end else begin
      if (wr && is_idx(wb_adr_i, `USS_IDX_BUS_MASK)) begin
        bus_mask_reg <= wbyte | `USS_BS_MASK_ONES;
      end
      if (wr && is_idx(wb_adr_i, `USS_IDX_REQ_MASK)) begin
        req_mask_reg <= wbyte | `USS_RS_MASK_ONES;
      end
    end
  end

  // Engine configuration; only suspend and a few control bits stored
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_reg <= `USS_RST_ENG_CFG;
    end else if (wr && is_idx(wb_adr_i, `USS_IDX_ENG_CFG)) begin
      cfg_reg <= wbyte & `USS_CFG_RW_BITS;
    end
  end

  // Summary latch: bus summary and setup indication, write-one clears
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sum_bus_reg      <= 1'b0;
      sum_setup_reg    <= 1'b0;
      sum_setup_en_reg <= 1'b0;
    end else begin
      if (wr && is_idx(wb_adr_i, `USS_IDX_SUMMARY)) begin
        // Set terms OR'd after the clear so a same-cycle event survives
        sum_bus_reg      <= (sum_bus_reg && !wbyte[`USS_SUM_BUS]) || bus_any;
        sum_setup_reg    <= (sum_setup_reg && !wbyte[`USS_SUM_SETUP])
                            || setup_unhandled_i;
        sum_setup_en_reg <= wbyte[`USS_SUM_SETUP_EN];
      end else begin
        sum_bus_reg   <= sum_bus_reg || bus_any;
        sum_setup_reg <= sum_setup_reg || setup_unhandled_i;
      end
    end
  end

  // Endpoint 0 stall bits: engine or software sets, setup or bus reset clears
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ep0_rx_stall_reg <= 1'b0;
      ep0_tx_stall_reg <= 1'b0;
    end else if (setup_unhandled_i || bus_reset_seen_i) begin
      // Setup clears stall even against a same-cycle set: stall must not outlive setup
      ep0_rx_stall_reg <= 1'b0;
      ep0_tx_stall_reg <= 1'b0;
    end else begin
      if (ep0_rx_stall_set_i || (wr && is_idx(wb_adr_i, `USS_IDX_EP0_CTL)
                                 && wbyte[`USS_EP_RX_STALL])) begin
        ep0_rx_stall_reg <= 1'b1;
      end
      if (ep0_tx_stall_set_i || (wr && is_idx(wb_adr_i, `USS_IDX_EP0_CTL)
                                 && wbyte[`USS_EP_TX_STALL])) begin
        ep0_tx_stall_reg <= 1'b1;
      end
    end
  end

  // Endpoint 0 expected toggles after a valid setup with DATA0
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ep0_rx_tog_reg <= 1'b0;
      ep0_tx_tog_reg <= 1'b0;
    end else if (setup_data0_valid_i) begin
      ep0_rx_tog_reg <= 1'b1;
      ep0_tx_tog_reg <= 1'b1;
    end else if (bus_reset_seen_i) begin
      ep0_rx_tog_reg <= 1'b0;
      ep0_tx_tog_reg <= 1'b0;
    end
  end

  // Wishbone answer: one cycle after the request, err for unmapped
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      err_reg <= 1'b0;
    end else begin
      ack_reg <= req && hit;
      err_reg <= req && !hit;
    end
  end

  // Read data mux, captured with the ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdat_reg <= 32'h0000_0000;
    end else if (req && hit && !wb_we_i) begin
      rdat_reg <= 32'h0000_0000;
      if (is_idx(wb_adr_i, `USS_IDX_BUS_STAT)) begin
        rdat_reg[7:0] <= bus_view;
      end
      if (is_idx(wb_adr_i, `USS_IDX_BUS_MASK)) begin
        rdat_reg[7:0] <= bus_mask_reg;
      end
      if (is_idx(wb_adr_i, `USS_IDX_REQ_MASK)) begin
        rdat_reg[7:0] <= req_mask_reg;
      end
      if (is_idx(wb_adr_i, `USS_IDX_REQ_STAT)) begin
        rdat_reg[7:0] <= req_stat_reg;
      end
      if (is_idx(wb_adr_i, `USS_IDX_ENG_CFG)) begin
        rdat_reg[7:0] <= cfg_reg;
      end
      if (is_idx(wb_adr_i, `USS_IDX_SUMMARY)) begin
        rdat_reg[`USS_SUM_SETUP]    <= sum_setup_reg;
        rdat_reg[`USS_SUM_BUS]      <= sum_bus_reg;
        rdat_reg[`USS_SUM_SETUP_EN] <= sum_setup_en_reg;
      end
      if (is_idx(wb_adr_i, `USS_IDX_EP0_CTL)) begin
        rdat_reg[`USS_EP_RX_STALL] <= ep0_rx_stall_reg;
        rdat_reg[`USS_EP_TX_STALL] <= ep0_tx_stall_reg;
        rdat_reg[`USS_EP_RX_TOG]   <= ep0_rx_tog_reg;
        rdat_reg[`USS_EP_TX_TOG]   <= ep0_tx_tog_reg;
      end
    end
  end

  // Outputs
  assign wb_ack_o               = ack_reg;
  assign wb_err_o               = err_reg;
  assign wb_dat_o               = rdat_reg;
  assign mcu_request_irq_line_o = |(req_stat_reg & ~req_mask_reg);
  assign setup_irq_o            = sum_setup_reg && sum_setup_en_reg;
  assign suspend_o              = cfg_reg[`USS_CFG_SUSPEND];
  assign resume_armed_o         = cfg_reg[`USS_CFG_SUSPEND];
  assign ep0_rx_stall_o         = ep0_rx_stall_reg;
  assign ep0_tx_stall_o         = ep0_tx_stall_reg;
  assign ep0_rx_toggle_o        = ep0_rx_tog_reg;
  assign ep0_tx_toggle_o        = ep0_tx_tog_reg;

endmodule
`default_nettype wire

/* inc/uss_params.svh */
// Register offsets, field positions, reset values for the status/interrupt block.
// Assumes inclusion by bare name from the package and the design file.
`ifndef USS_PARAMS_SVH
`define USS_PARAMS_SVH

// Register indices (printed offsets are not word multiples: byte addr = 4 * index)
`define USS_IDX_BUS_STAT     8'hab
`define USS_IDX_BUS_MASK     8'hac
`define USS_IDX_REQ_MASK     8'hae
`define USS_IDX_REQ_STAT     8'hb0
`define USS_IDX_ENG_CFG      8'haa
`define USS_IDX_SUMMARY      8'hb4
`define USS_IDX_EP0_CTL      8'hb5

// Reset values
`define USS_RST_BUS_STAT     8'h00
`define USS_RST_BUS_MASK     8'hff
`define USS_RST_REQ_MASK     8'hff
`define USS_RST_REQ_STAT     8'h00
`define USS_RST_ENG_CFG      8'h40

// Bus status field positions
`define USS_BS_BULK_DIR      6
`define USS_BS_HIGH_SPEED    5
`define USS_BS_RESUME        4
`define USS_BS_BUS_RESET     3
`define USS_BS_ERROR         2

// Writable bit sets and constant-one bits
`define USS_BS_W1C_BITS      8'h78
`define USS_BS_MASK_RW       8'h7c
`define USS_BS_MASK_ONES     8'h83
`define USS_RS_BITS          8'heb
`define USS_RS_MASK_ONES     8'h14

// Engine configuration field positions
`define USS_CFG_SUSPEND      0
`define USS_CFG_RW_BITS      8'h4b

// Interrupt summary field positions
`define USS_SUM_SETUP        0
`define USS_SUM_BUS          1
`define USS_SUM_SETUP_EN     4

// Endpoint 0 control/status field positions
`define USS_EP_RX_STALL      0
`define USS_EP_TX_STALL      1
`define USS_EP_RX_TOG        2
`define USS_EP_TX_TOG        3

`endif

/* inc/uss_pkg.sv */
// Types shared by the status/interrupt block.
// Assumes the params header is on the include path.
`include "uss_params.svh"

package uss_pkg;
  typedef logic [7:0]  uss_byte_t;   // One register byte
  typedef logic [29:0] uss_waddr_t;  // Wishbone word address
endpackage

/* sim/uss_status_irq_props.sv */
// Port-level properties of the status and interrupt block.
// Assumes one clock domain and a bind from the bench top file.
`timescale 1ns/1ps
`default_nettype none
`include "uss_params.svh"

module uss_status_irq_props (
  // Clock and reset
  input wire logic                clk_i,
  input wire logic                rst_i,
  // Register bus
  input wire logic                wb_cyc_i,
  input wire logic                wb_stb_i,
  input wire logic                wb_we_i,
  input wire uss_pkg::uss_waddr_t wb_adr_i,
  input wire logic                wb_ack_o,
  input wire logic                wb_err_o,
  // Engine events and block outputs
  input wire logic                bus_reset_seen_i,
  input wire logic                setup_unhandled_i,
  input wire logic                setup_data0_valid_i,
  input wire logic                mcu_request_irq_line_o,
  input wire logic                setup_irq_o,
  input wire logic                suspend_o,
  input wire logic                resume_armed_o,
  input wire logic                ep0_rx_stall_o,
  input wire logic                ep0_tx_stall_o,
  input wire logic                ep0_rx_toggle_o,
  input wire logic                ep0_tx_toggle_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  logic req_new; // Request not yet answered
  logic mapped;  // Index decodes to a register
  logic wr_seen; // Write request on the bus
  assign req_new = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  assign mapped = wb_adr_i inside {`USS_IDX_BUS_STAT, `USS_IDX_BUS_MASK, `USS_IDX_REQ_MASK,
    `USS_IDX_REQ_STAT, `USS_IDX_ENG_CFG, `USS_IDX_SUMMARY, `USS_IDX_EP0_CTL};
  assign wr_seen = wb_cyc_i && wb_we_i;

  // Bus handshake: one answer per request, one cycle long
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack stood longer than one cycle");
  a_ack_mapped: assert property (req_new && mapped |=> wb_ack_o && !wb_err_o)
    else $error("mapped access not acked next cycle");
  a_err_unmapped: assert property (req_new && !mapped |=> wb_err_o && !wb_ack_o)
    else $error("unmapped access not refused next cycle");
  a_idle_quiet: assert property (!wb_cyc_i |=> !wb_ack_o && !wb_err_o)
    else $error("answer without a request");
  // Endpoint 0 stall and toggle effects of a setup
  a_setup_unstall: assert property (setup_unhandled_i |=> !ep0_rx_stall_o && !ep0_tx_stall_o)
    else $error("stall survived an unhandled setup");
  a_setup_toggle: assert property (setup_data0_valid_i && !bus_reset_seen_i
    |=> ep0_rx_toggle_o && ep0_tx_toggle_o)
    else $error("toggles not DATA1 after setup");
  // Suspend arms resume detection, combinationally
  a_resume_armed: assert property (resume_armed_o == suspend_o)
    else $error("resume arming differs from suspend bit");
  // Interrupt lines fall only after a software write
  a_irq_fall: assert property ($fell(mcu_request_irq_line_o) && !$past(rst_i)
    |-> $past(wr_seen))
    else $error("request irq fell without a write");
  a_setup_irq_fall: assert property ($fell(setup_irq_o) && !$past(rst_i) |-> $past(wr_seen))
    else $error("setup irq fell without a write");
endmodule
`default_nettype wire

/* sim/uss_engine_model.sv */
// Behavioural packet engine: turns bench requests into one-cycle event pulses.
// Assumes the bench raises fire_i for exactly one cycle per event.
`timescale 1ns/1ps
`default_nettype none

module uss_engine_model (
  // Clock
  input  wire logic        clk_i,
  // Bench requests, one bit per event kind
  input  wire logic [13:0] fire_i,
  // Registered pulses toward the block
  output logic [13:0]      event_o
);
  // Registered so pulses launch just after an edge, as the real engine does
  always_ff @(posedge clk_i) begin
    event_o <= fire_i;
  end
endmodule
`default_nettype wire

/* sim/uss_status_irq_tb.sv */
// Self-checking bench for the status and interrupt block.
// Assumes package, params header, engine model and checker compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "uss_params.svh"

module uss_status_irq_tb;
  import uss_pkg::*;
  logic        clk_i = 1'b0;   // Bench clock
  logic        rst_i = 1'b1;   // Sync reset
  logic        cyc = 1'b0;     // Cycle and strobe together
  logic        we = 1'b0;      // Write strobe
  uss_waddr_t  adr = '0;       // Register index
  logic [31:0] wdat = '0;      // Write data
  logic [3:0]  sel = 4'h1;     // Low lane only
  logic [31:0] rdat;           // Read data
  logic        ack, err;       // Slave answers
  logic [13:0] fire = '0;      // Event requests to model
  logic [13:0] ev;             // Event pulses from model
  logic        err_lvl = 1'b0; // Error detail level
  logic        irq, sirq, susp, armed, rxs, txs, rxt, txt;
  logic        last_err;       // Refusal of last transfer
  uss_byte_t   q;              // Last byte read
  int          num_errors = 0;
  int          samples_checked = 0;
  int          cycles = 0;

  always #5 clk_i = ~clk_i;

  uss_engine_model uss_engine_model_i (.clk_i(clk_i), .fire_i(fire), .event_o(ev));
  uss_status_irq uss_status_irq_i (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .wb_err_o(err), .bulk_direction_fault_i(ev[0]), .high_speed_seen_i(ev[1]),
    .resume_seen_i(ev[2]), .bus_reset_seen_i(ev[3]), .error_recorded_i(err_lvl),
    .halt_set_req_i(ev[4]), .halt_release_req_i(ev[5]), .config_change_req_i(ev[6]),
    .interface_change_req_i(ev[7]), .wakeup_arm_req_i(ev[8]), .wakeup_disarm_req_i(ev[9]),
    .setup_unhandled_i(ev[10]), .setup_data0_valid_i(ev[11]), .ep0_rx_stall_set_i(ev[12]),
    .ep0_tx_stall_set_i(ev[13]), .mcu_request_irq_line_o(irq), .setup_irq_o(sirq),
    .suspend_o(susp), .resume_armed_o(armed), .ep0_rx_stall_o(rxs), .ep0_tx_stall_o(txs),
    .ep0_rx_toggle_o(rxt), .ep0_tx_toggle_o(txt));

  // Verdict in one place; hang guard feeds it too
  task automatic close_out();
    if (num_errors == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      close_out();
    end
  end

  // Classic single access; held until ack or err is sampled high
  task automatic xfer(input logic w, input uss_byte_t ix, input uss_byte_t d);
    cyc <= 1'b1;
    we <= w;
    adr <= uss_waddr_t'(ix);
    wdat <= {24'h00_0000, d};
    // No local cap: only the bench-wide cycle ceiling ends a hung wait
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1 && err !== 1'b1);
    q = rdat[7:0];
    last_err = err;
    cyc <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wr(input uss_byte_t ix, input uss_byte_t d);
    xfer(1'b1, ix, d);
  endtask
  task automatic chk_reg(input uss_byte_t ix, input uss_byte_t exp);
    xfer(1'b0, ix, 8'h00);
    samples_checked++;
    if (q !== exp) begin
      num_errors++;
      $display("CHECK FAILED %0t index %h read %h want %h", $time, ix, q, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %0t level %b want %b", $time, got, exp);
    end
  endtask
  // One-cycle event, then settle so reads see the flag
  task automatic pulse(input logic [13:0] v);
    fire <= v;
    @(posedge clk_i);
    fire <= '0;
    repeat (3) @(posedge clk_i);
  endtask

  initial begin
    int bb[3] = '{6, 5, 3};
    int be[3] = '{0, 1, 3};
    int rb[6] = '{7, 6, 5, 3, 1, 0};
    uss_byte_t m;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk_reg(`USS_IDX_BUS_STAT, 8'h00);
    chk_reg(`USS_IDX_BUS_MASK, 8'hff);
    chk_reg(`USS_IDX_REQ_MASK, 8'hff);
    chk_reg(`USS_IDX_REQ_STAT, 8'h00);
    chk_reg(8'hc0, 8'h00);
    chk_bit(last_err, 1'b1);
    sel <= 4'h0;
    wr(`USS_IDX_BUS_MASK, 8'h00);
    sel <= 4'h1;
    chk_reg(`USS_IDX_BUS_MASK, 8'hff);
    // Bus flags set by events, kept by zero writes, cleared by ones
    for (int i = 0; i < 3; i++) begin
      m = 8'h01 << bb[i];
      pulse(14'h0001 << be[i]);
      chk_reg(`USS_IDX_BUS_STAT, m);
      wr(`USS_IDX_BUS_STAT, ~m);
      chk_reg(`USS_IDX_BUS_STAT, m);
      wr(`USS_IDX_BUS_STAT, m);
      chk_reg(`USS_IDX_BUS_STAT, 8'h00);
    end
    // Resume counts only while suspended
    pulse(14'h0004);
    chk_reg(`USS_IDX_BUS_STAT, 8'h00);
    wr(`USS_IDX_ENG_CFG, 8'h41);
    chk_bit(armed, 1'b1);
    chk_bit(susp, 1'b1);
    pulse(14'h0004);
    chk_reg(`USS_IDX_BUS_STAT, 8'h10);
    wr(`USS_IDX_BUS_STAT, 8'h10);
    wr(`USS_IDX_ENG_CFG, 8'h40);
    chk_bit(susp | armed, 1'b0);
    // Error bit mirrors the level and ignores writes
    err_lvl <= 1'b1;
    wr(`USS_IDX_BUS_STAT, 8'hff);
    chk_reg(`USS_IDX_BUS_STAT, 8'h04);
    err_lvl <= 1'b0;
    chk_reg(`USS_IDX_BUS_STAT, 8'h00);
    wr(`USS_IDX_BUS_MASK, 8'h00);
    chk_reg(`USS_IDX_BUS_MASK, 8'h83);
    // Mask gates the summary latch, not the flag
    wr(`USS_IDX_BUS_MASK, 8'hff);
    pulse(14'h0001);
    chk_reg(`USS_IDX_BUS_STAT, 8'h40);
    chk_reg(`USS_IDX_SUMMARY, 8'h00);
    wr(`USS_IDX_BUS_MASK, 8'hbf);
    chk_reg(`USS_IDX_SUMMARY, 8'h02);
    wr(`USS_IDX_BUS_STAT, 8'h40);
    wr(`USS_IDX_SUMMARY, 8'h02);
    chk_reg(`USS_IDX_SUMMARY, 8'h00);
    wr(`USS_IDX_BUS_MASK, 8'hff);
    // Each request flag, its mask and the irq line
    for (int i = 0; i < 6; i++) begin
      m = 8'h01 << rb[i];
      pulse(14'h0010 << i);
      chk_reg(`USS_IDX_REQ_STAT, m);
      chk_bit(irq, 1'b0);
      wr(`USS_IDX_REQ_MASK, ~m);
      chk_bit(irq, 1'b1);
      wr(`USS_IDX_REQ_STAT, ~m);
      chk_bit(irq, 1'b1);
      wr(`USS_IDX_REQ_STAT, m);
      chk_bit(irq, 1'b0);
      wr(`USS_IDX_REQ_MASK, 8'hff);
    end
    wr(`USS_IDX_REQ_MASK, 8'h00);
    chk_reg(`USS_IDX_REQ_MASK, 8'h14);
    pulse(14'h03f0);
    chk_reg(`USS_IDX_REQ_STAT, 8'heb);
    wr(`USS_IDX_REQ_STAT, 8'hff);
    wr(`USS_IDX_REQ_MASK, 8'hff);
    chk_reg(`USS_IDX_REQ_STAT, 8'h00);
    // Event on the same edge as its clearing write
    fire <= 14'h0010;
    @(posedge clk_i);
    fire <= '0;
    wr(`USS_IDX_REQ_STAT, 8'h80);
    chk_reg(`USS_IDX_REQ_STAT, 8'h80);
    // Setup clears stalls, flags summary, sets toggles
    pulse(14'h3000);
    chk_bit(rxs & txs, 1'b1);
    pulse(14'h0400);
    chk_bit(rxs | txs, 1'b0);
    chk_reg(`USS_IDX_SUMMARY, 8'h01);
    chk_bit(sirq, 1'b0);
    wr(`USS_IDX_SUMMARY, 8'h10);
    chk_bit(sirq, 1'b1);
    pulse(14'h0800);
    chk_bit(rxt & txt, 1'b1);
    close_out();
  end
endmodule

bind uss_status_irq uss_status_irq_props uss_status_irq_props_i (
  .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_ack_o, .wb_err_o,
  .bus_reset_seen_i, .setup_unhandled_i, .setup_data0_valid_i, .mcu_request_irq_line_o,
  .setup_irq_o, .suspend_o, .resume_armed_o, .ep0_rx_stall_o, .ep0_tx_stall_o,
  .ep0_rx_toggle_o, .ep0_tx_toggle_o);
`default_nettype wire
